// *** hdl/swclk_pkg.sv ***
// Constants, types and lookup helpers for the switching clock select block.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
package swclk_pkg;
   // System clock rate
   localparam int MCLK_MHZ = 100;
   // Waits and upper limits round up to whole cycles
   function automatic int ns_up(input int ns);
      return (ns * MCLK_MHZ + 999) / 1000;
   endfunction
   // Lower period limit rounds down
   function automatic int ns_dn(input int ns);
      return (ns * MCLK_MHZ) / 1000;
   endfunction
   // Settling after bias rail good, then detect window
   localparam int SETTLE_NS = 10000;
   localparam int DET_WIN_NS = 10000;
   // Accepted incoming period: 1.4 MHz to 200 kHz
   localparam int PER_MIN_NS = 714;
   localparam int PER_MAX_NS = 5000;
   // No edge for this long means the clock is gone
   localparam int LOSS_NS = 7000;
   localparam int SETTLE_CYC = ns_up(SETTLE_NS);
   localparam int DET_WIN_CYC = ns_up(DET_WIN_NS);
   localparam int PER_MIN_CYC = ns_dn(PER_MIN_NS);
   localparam int PER_MAX_CYC = ns_up(PER_MAX_NS);
   localparam int LOSS_CYC = ns_up(LOSS_NS);
   localparam int EDGE_MIN = 2;
   // Reference for divided frequencies, in kHz
   localparam int REF_KHZ = 8000;
   localparam logic [5:0] DIV_MIN = 6'h06;
   localparam logic [5:0] DIV_MAX = 6'h28;
   // Fixed output-role rate and strap rates in kHz
   localparam int OUT_KHZ = 400;
   localparam int STRAP_LO_KHZ = 200;
   localparam int STRAP_OPEN_KHZ = 400;
   localparam int STRAP_HI_KHZ = 1000;
   // Half period in mclk is N*25/4; accumulator steps by 4
   localparam int HALF_MUL = 25;
   localparam logic [10:0] ACC_STEP = 11'h004;
   // Register byte offsets and fields
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] FREQ_OFS = 4'h4;
   localparam logic [3:0] STAT_OFS = 4'h8;
   localparam int CTRL_POLICY = 0;
   localparam int CTRL_LOWPWR = 1;
   localparam int CTRL_MONITOR = 2;
   localparam logic [2:0] CTRL_RST = 3'h1;
   localparam int RES_ENTRIES = 19;
   // Pin-level sense of a three-state / resistor pin
   typedef struct packed {
      logic hi;
      logic lo;
      logic res;
      logic [4:0] res_idx;
   } pin_sense_t;
   // Role of the shared clock pin
   typedef enum logic [1:0] {
      ROLE_IN = 2'b00, ROLE_AUTO = 2'b01, ROLE_OUT = 2'b10
   } role_t;
   // Resistor table, frequency in kHz per standard resistor index
   function automatic int res_khz(input logic [4:0] idx);
      case (idx)
         5'h00: return 200;  5'h01: return 222;  5'h02: return 242;
         5'h03: return 267;  5'h04: return 296;  5'h05: return 320;
         5'h06: return 364;  5'h07: return 400;  5'h08: return 421;
         5'h09: return 471;  5'h0a: return 533;  5'h0b: return 571;
         5'h0c: return 615;  5'h0d: return 727;  5'h0e: return 800;
         5'h0f: return 889;  5'h10: return 1000; 5'h11: return 1143;
         default: return 1333;
      endcase
   endfunction
   // Divider whose frequency lies closest to the request
   function automatic logic [5:0] nearest_div(input int khz);
      int best;
      int d;
      logic [5:0] n;
      best = 32'h7fffffff;
      n = DIV_MIN;
      for (int i = 6; i <= 40; i++) begin
         d = khz * 1000 - (REF_KHZ * 1000) / i;
         if (d < 0) begin
            d = -d;
         end
         if (d < best) begin
            best = d;
            n = 6'(i);
         end
      end
      return n;
   endfunction
   // Quantized frequency in kHz for a divider
   function automatic logic [15:0] quant_khz(input logic [5:0] n);
      logic [15:0] f;
      f = 16'h0000;
      for (int i = 6; i <= 40; i++) begin
         if (n == 6'(i)) begin
            f = 16'(REF_KHZ / i);
         end
      end
      return f;
   endfunction
endpackage

// *** hdl/switching_clock_select.sv ***
// Switching clock source and rate selection with sync pin handling.
// Assumes straps and pin sense come from analog front ends as static
// levels, and that sync_clk is the buffered sync pin input clock.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
// Summary of operation
// RULE1: Role strap sets pin input, auto, output
// RULE2: Output role drives internal oscillator, no detect
// RULE3: Self-enabled or monitor detects after power-up
// RULE4: Source gives stable 200k-1.4M clock early
// RULE5: Low power mode detects after enable rises
// RULE6: Detected clock: lock to its rising edges
// RULE7: Clock loss: internal oscillator, last frequency
// RULE8: Auto without clock: rate from pin strap
// RULE9: Pin strap sampled only at first start-up
// RULE10: Resistor index maps to table frequency
// RULE11: Bus frequency is 8 MHz over 6..40
// RULE12: Bus request rounds to nearest valid frequency
// RULE13: Read-back shows quantized hardware frequency
// RULE14: Low power means standby low power setting
// RULE15: Clock present only if edges in range
module switching_clock_select
   import swclk_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic sync_clk, // Incoming clock on the shared pin
   input wire logic role_strap_hi, // clock_role_strap tied high
   input wire logic role_strap_lo, // clock_role_strap tied low
   input wire pin_sense_t sync_sense, // Static state of the pin
   input wire logic bias_good, // internal_bias_rail above threshold
   input wire logic en_pin,
   input wire logic en_tied_bias,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic sw_clk, // Switching clock to the power stage
   output logic sync_pin_o,
   output logic sync_pin_oe_n,
   output logic locked
);
   typedef enum logic [2:0] {
      ST_BIAS = 3'b000, ST_SETTLE = 3'b001, ST_WAIT_EN = 3'b010,
      ST_DETECT = 3'b011, ST_RUN = 3'b100, ST_SYNCED = 3'b101,
      ST_HOLD = 3'b110
   } state_t;

   // Link domain: gray count of incoming rising edges
   logic [2:0] lgray_r, lgray_nxt;
   always_comb begin
      lgray_nxt = lgray_r ^ ((^lgray_r) ? {~lgray_r[0],
         lgray_r[0], 1'b0} : 3'h1);
   end
   always_ff @(posedge sync_clk or posedge rst) begin
      if (rst) begin
         lgray_r <= 3'h0;
      end else begin
         lgray_r <= lgray_nxt;
      end
   end

   // Synchronisers; first stage feeds only the second
   logic [2:0] g1_r, g2_r, g3_r;
   logic [12:0] in1_r, in2_r; // Straps, sense, bias, enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         g1_r <= 3'h0;
         g2_r <= 3'h0;
         g3_r <= 3'h0;
         in1_r <= 13'h0000;
         in2_r <= 13'h0000;
      end else begin
         g1_r <= lgray_r;
         g2_r <= g1_r;
         g3_r <= g2_r;
         in1_r <= {role_strap_hi, role_strap_lo, sync_sense, bias_good,
            en_pin, en_tied_bias};
         in2_r <= in1_r;
      end
   end
   // Pointer steps at most once per mclk at accepted rates
   wire edge_in = (g2_r != g3_r);
   wire pin_sense_t sense_s = in2_r[10:3];
   wire bias_s = in2_r[2];
   wire en_s = in2_r[1];
   wire tied_s = in2_r[0];
   // RULE1: role strap decode
   wire role_t role_s = in2_r[12] ? ROLE_OUT :
      (in2_r[11] ? ROLE_IN : ROLE_AUTO);

   // Control state
   state_t state_r, state_nxt;
   logic [2:0] ctrl_r, ctrl_nxt; // Policy, low power, monitor
   logic [5:0] div_r, div_nxt; // Active divider
   logic [5:0] strap_n_r, strap_n_nxt; // Divider from start-up strap
   logic [5:0] bus_n_r, bus_n_nxt; // Divider from bus request
   logic bus_set_r, bus_set_nxt;
   logic strap_done_r, strap_done_nxt;
   logic [10:0] tmr_r, tmr_nxt; // Settle and window timer
   logic [9:0] per_r, per_nxt; // Cycles since last edge
   logic [4:0] ecnt_r, ecnt_nxt; // Edges in detect window
   logic per_bad_r, per_bad_nxt;
   logic en_d_r, en_d_nxt;
   logic [10:0] acc_r, acc_nxt; // Oscillator phase
   logic osc_r, osc_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic oe_n_r, oe_n_nxt;
   logic lock_r, lock_nxt; // Synchronized to the incoming clock

   // Local decodes
   wire req = wb_cyc_i & wb_stb_i & ~ack_r;
   // RULE14: low power is the standby setting bit
   wire low_pwr = ctrl_r[CTRL_LOWPWR];
   // RULE3: self-enabled by tie, cleared policy bit or set monitor bit
   wire self_en = tied_s | ~ctrl_r[CTRL_POLICY] | ctrl_r[CTRL_MONITOR];
   wire per_ok = (per_r >= 10'(PER_MIN_CYC)) &&
      (per_r <= 10'(PER_MAX_CYC));
   wire [9:0] per_meas = 10'((int'(per_r) * 8 + 50) / 100);
   // Accumulator level at which the oscillator toggles
   wire [10:0] half_lim = 11'(int'(div_r) * HALF_MUL);

   // Next-state logic for control, oscillator and bus
   always_comb begin
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      div_nxt = div_r;
      strap_n_nxt = strap_n_r;
      bus_n_nxt = bus_n_r;
      bus_set_nxt = bus_set_r;
      strap_done_nxt = strap_done_r;
      tmr_nxt = tmr_r + 11'h001;
      per_nxt = (per_r == 10'h3ff) ? per_r : per_r + 10'h001;
      ecnt_nxt = ecnt_r;
      per_bad_nxt = per_bad_r;
      en_d_nxt = en_s;
      ack_nxt = req;
      dat_nxt = 32'h0000_0000;
      oe_n_nxt = (role_s != ROLE_OUT);
      // Measure the incoming period at every edge
      if (edge_in) begin
         per_nxt = 10'h001;
         ecnt_nxt = (ecnt_r == 5'h1f) ? ecnt_r : ecnt_r + 5'h01;
         // RULE15: one out-of-range period rejects the clock
         if (ecnt_r != 5'h00 && !per_ok) begin
            per_bad_nxt = 1'b1;
         end
      end
      unique case (state_r)
         ST_BIAS: begin
            tmr_nxt = 11'h000;
            if (bias_s) begin
               // RULE9: strap read once, kept until power cycle
               if (!strap_done_r) begin
                  strap_done_nxt = 1'b1;
                  // RULE8: static pin state picks the rate
                  if (sense_s.res) begin
                     // RULE10: resistor table lookup
                     strap_n_nxt = nearest_div(res_khz(sense_s.res_idx));
                  end else if (sense_s.hi) begin
                     strap_n_nxt = nearest_div(STRAP_HI_KHZ);
                  end else if (sense_s.lo) begin
                     strap_n_nxt = nearest_div(STRAP_LO_KHZ);
                  end else begin
                     strap_n_nxt = nearest_div(STRAP_OPEN_KHZ);
                  end
               end
               state_nxt = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (tmr_r == 11'(SETTLE_CYC - 1)) begin
               tmr_nxt = 11'h000;
               // RULE2: output role never looks for a clock
               if (role_s == ROLE_OUT) begin
                  div_nxt = nearest_div(OUT_KHZ);
                  state_nxt = ST_RUN;
               // RULE5: low power waits for enable
               end else if (low_pwr && !self_en) begin
                  state_nxt = ST_WAIT_EN;
               // RULE3: detect right after power-up
               end else begin
                  ecnt_nxt = 5'h00;
                  per_bad_nxt = 1'b0;
                  state_nxt = ST_DETECT;
               end
            end
         end
         ST_WAIT_EN: begin
            tmr_nxt = 11'h000;
            // RULE5: detect once enable goes true
            if (en_s && !en_d_r) begin
               ecnt_nxt = 5'h00;
               per_bad_nxt = 1'b0;
               state_nxt = ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (tmr_r == 11'(DET_WIN_CYC - 1)) begin
               // RULE15: enough edges and all periods in range
               if (ecnt_r >= 5'(EDGE_MIN) && !per_bad_r) begin
                  state_nxt = ST_SYNCED;
               end else begin
                  // RULE8: auto falls back to strap rate
                  div_nxt = (role_s == ROLE_AUTO) ? strap_n_r :
                     nearest_div(OUT_KHZ);
                  state_nxt = ST_RUN;
               end
            end
         end
         ST_SYNCED: begin
            // Track the incoming rate for a later holdover
            if (edge_in && per_ok) begin
               div_nxt = (per_meas < 10'(DIV_MIN)) ? DIV_MIN :
                  ((per_meas > 10'(DIV_MAX)) ? DIV_MAX : per_meas[5:0]);
            end
            // RULE7: loss keeps the last incoming divider
            if (per_r >= 10'(LOSS_CYC)) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_RUN, ST_HOLD: begin
            if (bus_set_r && role_s != ROLE_OUT) begin
               div_nxt = bus_n_r;
            end
         end
         default: begin
            state_nxt = ST_BIAS;
         end
      endcase
      lock_nxt = (state_nxt == ST_SYNCED);
      // Internal oscillator; phase reset locks to incoming edges
      acc_nxt = acc_r + ACC_STEP;
      osc_nxt = osc_r;
      // Remainder kept for an exact rate; a shrunk divider restarts
      if (acc_nxt >= half_lim) begin
         acc_nxt = (acc_r >= half_lim) ? 11'h000 : acc_nxt - half_lim;
         osc_nxt = ~osc_r;
      end
      // RULE6: rising incoming edge restarts the high half
      if (state_r == ST_SYNCED && edge_in) begin
         acc_nxt = 11'h000;
         osc_nxt = 1'b1;
      end
      // Register access
      if (req) begin
         unique case (wb_adr_i)
            CTRL_OFS: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  ctrl_nxt = wb_dat_i[2:0];
               end
               dat_nxt = {29'h0, ctrl_r};
            end
            FREQ_OFS: begin
               // RULE11: only 8 MHz over 6..40 is stored
               // RULE12: nearest valid frequency wins
               if (wb_we_i && wb_sel_i[1:0] == 2'h3) begin
                  bus_n_nxt = nearest_div(int'(wb_dat_i[15:0]));
                  bus_set_nxt = 1'b1;
               end
               // RULE13: quantized read-back
               dat_nxt = {16'h0, quant_khz(div_r)};
            end
            STAT_OFS: begin
               dat_nxt = {16'h0, div_r, 3'h0, state_r, role_s,
                  per_bad_r, strap_done_r};
            end
            default: begin
               dat_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_BIAS;
         ctrl_r <= CTRL_RST;
         div_r <= DIV_MAX;
         strap_n_r <= DIV_MAX;
         bus_n_r <= DIV_MAX;
         bus_set_r <= 1'b0;
         strap_done_r <= 1'b0;
         tmr_r <= 11'h000;
         per_r <= 10'h3ff;
         ecnt_r <= 5'h00;
         per_bad_r <= 1'b0;
         en_d_r <= 1'b0;
         acc_r <= 11'h000;
         osc_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         oe_n_r <= 1'b1;
         lock_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         div_r <= div_nxt;
         strap_n_r <= strap_n_nxt;
         bus_n_r <= bus_n_nxt;
         bus_set_r <= bus_set_nxt;
         strap_done_r <= strap_done_nxt;
         tmr_r <= tmr_nxt;
         per_r <= per_nxt;
         ecnt_r <= ecnt_nxt;
         per_bad_r <= per_bad_nxt;
         en_d_r <= en_d_nxt;
         acc_r <= acc_nxt;
         osc_r <= osc_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         oe_n_r <= oe_n_nxt;
         lock_r <= lock_nxt;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign sw_clk = osc_r;
   // RULE2: pin carries the oscillator in output role
   assign sync_pin_o = osc_r;
   assign sync_pin_oe_n = oe_n_r;
   assign locked = lock_r;

   // Checks
   sequence s_synced_quiet;
      state_r == ST_SYNCED && per_r == 10'(LOSS_CYC) && !edge_in;
   endsequence
   sequence s_enter_hold;
      state_r == ST_HOLD && $stable(div_r);
   endsequence
   pin_drive_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      role_s == ROLE_OUT |=> sync_pin_oe_n == 1'b0)
      else $error("Output role does not drive the pin");
   out_rate_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      state_r == ST_SETTLE && state_nxt == ST_RUN |=>
      div_r == 6'(REF_KHZ / OUT_KHZ))
      else $error("Output role rate is not 400 kHz");
   powerup_det_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
      state_r == ST_SETTLE && tmr_r == 11'(SETTLE_CYC - 1) &&
      role_s != ROLE_OUT && self_en |=> state_r == ST_DETECT)
      else $error("No detect after power-up");
   enable_det_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
      state_r == ST_WAIT_EN && en_s && !en_d_r |=> state_r == ST_DETECT)
      else $error("No detect after enable");
   edge_lock_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
      state_r == ST_SYNCED && edge_in |=> osc_r && acc_r == 11'h000)
      else $error("Oscillator not restarted on edge");
   loss_hold_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
      s_synced_quiet |=> s_enter_hold)
      else $error("Clock loss not handled");
   strap_once_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
      strap_done_r |=> $stable(strap_n_r))
      else $error("Strap divider changed after start-up");
   bus_range_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
      bus_n_r >= DIV_MIN && bus_n_r <= DIV_MAX)
      else $error("Bus divider out of range");
   detect_ok_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
      state_r == ST_DETECT ##1 state_r == ST_SYNCED |->
      $past(ecnt_r) >= 5'(EDGE_MIN) && !$past(per_bad_r))
      else $error("Clock accepted without valid edges");
endmodule

// *** sim/ext_clk_src.sv ***
// Behavioural clock source standing on the far side of the shared pin.
// Assumes the bench sets run and the half period; idle pin rests low.
`timescale 1ns/100ps
module ext_clk_src (
   input wire logic run, // Source enabled
   input wire logic [15:0] half_ns, // Half period in ns
   output logic clk_o // Clock onto the shared pin
);
   // steady clock, started early
   // Phase offset keeps it unrelated to the system clock
   always begin
      if (run !== 1'b1) begin
         clk_o = 1'b0;
         @(posedge run);
         #13.3;
      end else begin
         clk_o = 1'b1;
         #(half_ns);
         clk_o = 1'b0;
         #(half_ns);
      end
   end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the switching clock select block.
// Assumes classic Wishbone registers and an external clock model.
`timescale 1ns/100ps
module tb_top;
   import swclk_pkg::*;
   logic mclk = 1'b0;
   logic rst, sync_clk, role_hi, role_lo, bias_good, en_pin, en_tied;
   pin_sense_t sense; // Static pin state seen by the block
   logic cyc, stb, we, ack, sw_clk, pin_o, pin_oe_n, locked, run;
   logic [3:0] adr, sel, wsel;
   logic [31:0] wdat, dat_o, rd;
   logic [15:0] half_ns; // Partner half period
   int num_errors = 0;
   int n_checks = 0;
   int cnt;
   // Strap table: pin code and divider
   logic [7:0] st_pin [6] = '{8'h00, 8'h40, 8'h80, 8'h20, 8'h2f, 8'h32};
   int st_div [6] = '{20, 40, 8, 40, 9, 6};
   // Bus requests in kHz and the divider they round to
   logic [15:0] rq_khz [4] = '{16'h032a, 16'h0064, 16'h07d0, 16'h00d2};
   int rq_div [4] = '{10, 40, 6, 38};
   // Half period of 5 ns gives 100 MHz
   always #5 mclk = ~mclk;
   ext_clk_src src (.run(run), .half_ns(half_ns), .clk_o(sync_clk));
   switching_clock_select dut (.mclk(mclk), .rst(rst), .sync_clk(sync_clk),
      .role_strap_hi(role_hi), .role_strap_lo(role_lo), .sync_sense(sense),
      .bias_good(bias_good), .en_pin(en_pin), .en_tied_bias(en_tied),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .sw_clk(sw_clk), .sync_pin_o(pin_o), .sync_pin_oe_n(pin_oe_n),
      .locked(locked));
   // Verdict and end of run
   task automatic final_report();
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Exact value compare
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Cycle count compare, with a tolerance band
   task automatic chk_rng(input string nm, input int lo, input int hi,
      input int g);
      n_checks++;
      if (g < lo || g > hi) begin
         num_errors++;
         $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask
   // A wait ran out of its bound
   task automatic tmo(input string nm);
      num_errors++;
      $display("[ERR] %s exp done got timeout", nm);
      final_report();
   endtask
   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int i;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= wsel;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (ack !== 1'b1) tmo("wb ack");
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // Poll the status state field
   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 2000; i++) begin
         wb(1'b0, STAT_OFS, 32'h0);
         if (rd[6:4] === s) break;
      end
      if (rd[6:4] !== s) tmo("state wait");
   endtask
   // Reset with bias low; control written before bias rises
   task automatic power_up(input logic hi, input logic lo,
      input pin_sense_t ps, input logic tie, input logic [2:0] c);
      rst <= 1'b1;
      bias_good <= 1'b0;
      en_pin <= 1'b0;
      role_hi <= hi;
      role_lo <= lo;
      sense <= ps;
      en_tied <= tie;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      if (c !== CTRL_RST) wb(1'b1, CTRL_OFS, {29'h0, c});
      bias_good <= 1'b1;
   endtask
   // Cycles spanned by two switching clock periods
   task automatic meas(output int n);
      int e;
      logic p;
      n = 0;
      e = 0;
      p = sw_clk;
      for (int i = 0; i < 3000 && e < 3; i++) begin
         @(posedge mclk);
         if (e > 0) n++;
         if (sw_clk === 1'b1 && p === 1'b0) e++;
         p = sw_clk;
      end
      if (e < 3) tmo("sw_clk edges");
   endtask
   // Bounded wait for a rising link edge, seen at an mclk edge
   task automatic wait_link();
      logic p;
      int i;
      i = 0;
      do begin
         p = sync_clk;
         @(posedge mclk);
         i++;
      end while (!(sync_clk === 1'b1 && p === 1'b0) && i < 1000);
      if (!(sync_clk === 1'b1 && p === 1'b0)) tmo("link edge");
   endtask
   // Reset value, byte-select gating, unmapped offset
   task automatic sc_regs();
      power_up(1'b0, 1'b0, 8'h00, 1'b1, CTRL_RST);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h1, rd);
      wsel = 4'h0;
      wb(1'b1, CTRL_OFS, 32'h7);
      wsel = 4'hf;
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl no sel", 32'h1, rd);
      wb(1'b1, CTRL_OFS, 32'h7);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl rw", 32'h7, rd);
      wb(1'b0, 4'hc, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask
   // Auto role without clock: strap rates, one-time sampling, bus rates
   task automatic sc_straps();
      int per;
      for (int k = 0; k < 6; k++) begin
         power_up(1'b0, 1'b0, st_pin[k], 1'b1, CTRL_RST);
         wait_st(3'h4);
         wb(1'b0, FREQ_OFS, 32'h0);
         chk("strap khz", REF_KHZ / st_div[k], rd);
         chk("auto oe_n", 32'h1, {31'h0, pin_oe_n});
         meas(cnt);
         per = HALF_MUL * st_div[k];
         chk_rng("strap per", per - 2, per + 2, cnt);
      end
      // Pin moved after start-up; rate must hold
      sense <= 8'h80;
      repeat (50) @(posedge mclk);
      wb(1'b0, FREQ_OFS, 32'h0);
      chk("late strap", REF_KHZ / 6, rd);
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, FREQ_OFS, {16'h0, rq_khz[k]});
         wb(1'b0, FREQ_OFS, 32'h0);
         chk("bus khz", REF_KHZ / rq_div[k], rd);
         meas(cnt);
         per = HALF_MUL * rq_div[k];
         chk_rng("bus per", per - 2, per + 2, cnt);
      end
   endtask
   // Output role drives its own 400 kHz, ignores incoming clock
   task automatic sc_out();
      power_up(1'b1, 1'b0, 8'h00, 1'b1, CTRL_RST);
      half_ns <= 16'h03e8;
      run <= 1'b1;
      wait_st(3'h4);
      chk("out role", 32'h2, {30'h0, rd[3:2]});
      chk("out oe_n", 32'h0, {31'h0, pin_oe_n});
      chk("out lock", 32'h0, {31'h0, locked});
      meas(cnt);
      chk_rng("out per", 498, 502, cnt);
      cnt = 0;
      for (int i = 0; i < 300; i++) begin
         @(posedge mclk);
         if (pin_o !== sw_clk) cnt++;
      end
      chk_rng("pin drive", 0, 0, cnt);
      run <= 1'b0;
   endtask
   // Input role, policy bit clear: lock, phase, then loss and hold
   task automatic sc_lock();
      power_up(1'b0, 1'b1, 8'h00, 1'b0, 3'h0);
      half_ns <= 16'h03e8;
      run <= 1'b1;
      wait_st(3'h5);
      chk("lock", 32'h1, {31'h0, locked});
      meas(cnt);
      chk_rng("lock per", 398, 402, cnt);
      wait_link();
      cnt = 0;
      while (sw_clk !== 1'b1 && cnt < 50) begin
         @(posedge mclk);
         cnt++;
      end
      chk_rng("phase", 1, 5, cnt);
      // Stop the source right after a rising edge
      wait_link();
      run <= 1'b0;
      cnt = 1;
      while (locked === 1'b1 && cnt < 1000) begin
         @(posedge mclk);
         cnt++;
      end
      chk_rng("loss time", 700, 712, cnt);
      wait_st(3'h6);
      meas(cnt);
      chk_rng("hold per", 398, 402, cnt);
      wb(1'b0, FREQ_OFS, 32'h0);
      chk("hold khz", REF_KHZ / 16, rd);
   endtask
   // Monitor mode, 64 ns link clock: out of range, no lock
   task automatic sc_oor();
      power_up(1'b0, 1'b1, 8'h00, 1'b0, 3'h7);
      half_ns <= 16'h0020;
      run <= 1'b1;
      wait_st(3'h4);
      chk("fast lock", 32'h0, {31'h0, locked});
      wb(1'b0, FREQ_OFS, 32'h0);
      chk("in khz", OUT_KHZ, rd);
      run <= 1'b0;
   endtask
   // Low power standby: detection waits for enable
   task automatic sc_lowpwr();
      power_up(1'b0, 1'b1, 8'h00, 1'b0, 3'h3);
      half_ns <= 16'h01f4;
      run <= 1'b1;
      repeat (2100) @(posedge mclk);
      wb(1'b0, STAT_OFS, 32'h0);
      chk("lp wait", 32'h2, {29'h0, rd[6:4]});
      chk("lp lock", 32'h0, {31'h0, locked});
      en_pin <= 1'b1;
      wait_st(3'h5);
      chk("lp synced", 32'h1, {31'h0, locked});
      run <= 1'b0;
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      role_hi = 1'b0;
      role_lo = 1'b0;
      bias_good = 1'b0;
      en_pin = 1'b0;
      en_tied = 1'b0;
      sense = 8'h00;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'h0;
      wsel = 4'hf;
      wdat = 32'h0;
      run = 1'b0;
      half_ns = 16'h03e8;
      sc_regs();
      sc_straps();
      sc_out();
      sc_lock();
      sc_oor();
      sc_lowpwr();
      final_report();
   end
endmodule
